// File: ogc_top.sv
// How it works
// (RULE1) five control pins, each bound to one role at configuration
// (RULE2) master and each bank disable may sit on any of the five pins
// (RULE3) master disable low lets each bank follow its own disable, high stops all banks
// (RULE4) four banks of two outputs, each bank with its own disable
// (RULE5) disabled bank holds both its outputs low
// (RULE6) start and stop only at full phases, no short pulses
// (RULE7) plan select low only on second pin, high only on third
// (RULE8) reset only on first, third, fourth or fifth pin; reloads plan
// (RULE9) up to three stored frequency plans, ratios for every bank
// (RULE10) reference source fixed by stored configuration, not by pins
// (RULE11) four bank dividers and one feedback divider from one source
// (RULE12) dividers alternate two nearest integers for exact average ratio
// (RULE13) every bank path can reach any frequency in the output range; code tops out at SRC_KHZ/2 = 50000 kHz, below F_MAX_KHZ
// (RULE14) select code 01,10,11 picks plans one to three; two-plan uses high
// (RULE15) reset held minimum width, outputs squelch, resume with new plan
// (RULE16) without a reset pin plan changes only at power-on reset
// (RULE17) bank runs only when master and bank disables are both low
// (RULE18) disables registered and applied only while bank clock is low
`timescale 1ns/100ps

module ogc_top (
	// clock and reset
	input  wire logic       CORE_CLK,
	input  wire logic       RESETN,
	// multi-function control pins
	input  wire logic       MULTI_PIN_FIRST,
	input  wire logic       MULTI_PIN_SECOND,
	input  wire logic       MULTI_PIN_THIRD,
	input  wire logic       MULTI_PIN_FOURTH,
	input  wire logic       MULTI_PIN_FIFTH,
	// bank clock outputs
	output logic [1:0]      BANK_A_CLOCK_PAIR,
	output logic [1:0]      BANK_B_CLOCK_PAIR,
	output logic [1:0]      BANK_C_CLOCK_PAIR,
	output logic [1:0]      BANK_D_CLOCK_PAIR,
	// status
	output logic            FB_CLK,
	output logic [1:0]      ACTIVE_PLAN,
	output logic            REF_IS_CRYSTAL,
	output logic            SQUELCH
);

	localparam int NB = ogc_pkg::NUM_BANKS;
	localparam int ND = ogc_pkg::NUM_DIVS;

	// (RULE7) select lines fixed to their pins
	// (RULE8) reset never on the second pin
	for (genvar p = 0; p < ogc_pkg::NUM_PINS; p++) begin : g_chk_pin
		if (ogc_pkg::PIN_MAP[p] == ogc_pkg::FN_SEL_LOW && p != ogc_pkg::PIN_SECOND)
			$error("plan select low placed off the second pin");
		if (ogc_pkg::PIN_MAP[p] == ogc_pkg::FN_SEL_HIGH && p != ogc_pkg::PIN_THIRD)
			$error("plan select high placed off the third pin");
		if (ogc_pkg::PIN_MAP[p] == ogc_pkg::FN_RESET && p == ogc_pkg::PIN_SECOND)
			$error("reset placed on the second pin");
	end
	if (ogc_pkg::PLAN_COUNT < 1 || ogc_pkg::PLAN_COUNT > ogc_pkg::NUM_PLANS)
		$error("unsupported plan count");
	// (RULE13) ratios must be well formed and inside the frequency range
	for (genvar n = 0; n < ogc_pkg::NUM_PLANS; n++) begin : g_chk_plan
		for (genvar b = 0; b < NB; b++) begin : g_chk_bank
			localparam ogc_pkg::ogc_ratio_t R = ogc_pkg::PLAN_TABLE[n].bank[b];
			if (R.whole == 16'h0000 || R.den == 16'h0000 || R.num >= R.den)
				$error("malformed divider ratio");
			if (ogc_pkg::SRC_KHZ / (2 * (int'(R.whole) + 1)) < ogc_pkg::F_MIN_KHZ
				|| ogc_pkg::SRC_KHZ / (2 * int'(R.whole)) > ogc_pkg::F_MAX_KHZ)
				$error("divider ratio outside output range");
		end
	end

	// level of the pin carrying a role, default when no pin has it
	function automatic logic pin_role(ogc_pkg::ogc_fn_t fn, logic [4:0] pins, logic dflt);
		logic v;
		v = dflt;
		for (int i = 0; i < ogc_pkg::NUM_PINS; i++) begin
			if (ogc_pkg::PIN_MAP[i] == fn) begin
				v = pins[i];
			end
		end
		return v;
	endfunction

	typedef enum {ST_WAKE, ST_LOAD, ST_RUN, ST_HOLD} ogc_state_t;

	logic [4:0]                  pins;
	ogc_pkg::ogc_roles_t         roles_d, roles_q;
	ogc_state_t                  st_d, st_q;
	logic [ogc_pkg::RST_CNT_W-1:0] rcnt_d, rcnt_q;
	logic [1:0]                  plan_d, plan_q;
	logic                        restart;
	logic [ND-1:0]               div_clk;
	ogc_pkg::ogc_ratio_t         ratio [ND];
	logic [NB-1:0]               run_d, run_q;
	logic [NB-1:0]               out_d, out_q;
	logic                        fb_d, fb_q;
	logic                        sq_d, sq_q;

	assign pins = {MULTI_PIN_FIFTH, MULTI_PIN_FOURTH, MULTI_PIN_THIRD,
		MULTI_PIN_SECOND, MULTI_PIN_FIRST};

	// (RULE1) roles decoded from the configured pin map
	// (RULE2) disables taken from whichever pin holds them
	always_comb begin
		roles_d.master_out_disable_n = pin_role(ogc_pkg::FN_MASTER, pins, 1'b0);
		roles_d.bank_disable_n[0]    = pin_role(ogc_pkg::FN_BANK_A, pins, 1'b0);
		roles_d.bank_disable_n[1]    = pin_role(ogc_pkg::FN_BANK_B, pins, 1'b0);
		roles_d.bank_disable_n[2]    = pin_role(ogc_pkg::FN_BANK_C, pins, 1'b0);
		roles_d.bank_disable_n[3]    = pin_role(ogc_pkg::FN_BANK_D, pins, 1'b0);
		roles_d.plan_select_bus[0]   = pin_role(ogc_pkg::FN_SEL_LOW, pins, 1'b0);
		roles_d.plan_select_bus[1]   = pin_role(ogc_pkg::FN_SEL_HIGH, pins, 1'b0);
		roles_d.reset                = pin_role(ogc_pkg::FN_RESET, pins, 1'b0);
	end

	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			roles_q <= '0;
		end else begin
			roles_q <= roles_d;
		end
	end

	// plan load sequence
	always_comb begin
		st_d   = st_q;
		rcnt_d = rcnt_q;
		plan_d = plan_q;
		case (st_q)
			ST_WAKE: begin
				// (RULE16) one edge so the select pins are registered before load
				st_d = ST_LOAD;
			end
			ST_LOAD: begin
				// (RULE14) select code to plan index
				if (ogc_pkg::PLAN_COUNT == 2) begin
					plan_d = {1'b0, roles_q.plan_select_bus[1]};
				end else if (roles_q.plan_select_bus == 2'h0) begin
					plan_d = ogc_pkg::PLAN_RST;
				end else begin
					plan_d = roles_q.plan_select_bus - 2'h1;
				end
				st_d = ST_RUN;
			end
			ST_RUN: begin
				// (RULE16) no reset pin keeps this state until power-on reset
				if (roles_q.reset) begin
					st_d   = ST_HOLD;
					rcnt_d = {{(ogc_pkg::RST_CNT_W-1){1'b0}}, 1'b1};
				end
			end
			ST_HOLD: begin
				// (RULE15) reload only after minimum pulse width
				if (!roles_q.reset) begin
					st_d = (rcnt_q >= ogc_pkg::RST_MIN_CYC) ? ST_LOAD : ST_RUN;
				end else if (rcnt_q < ogc_pkg::RST_MIN_CYC) begin
					rcnt_d = rcnt_q + 1'b1;
				end
			end
			default: begin
				st_d = ST_LOAD;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			st_q   <= ST_WAKE;
			rcnt_q <= '0;
			plan_q <= ogc_pkg::PLAN_RST;
		end else begin
			st_q   <= st_d;
			rcnt_q <= rcnt_d;
			plan_q <= plan_d;
		end
	end

	// (RULE8) dividers restart in the load cycle; the first half period still uses the previous plan's whole
	assign restart = (st_q == ST_LOAD);

	// (RULE9) ratios from the active stored plan
	// (RULE11) four bank dividers plus feedback divider, one source
	for (genvar d = 0; d < ND; d++) begin : g_div
		if (d == ogc_pkg::FB_DIV) begin : g_fb
			assign ratio[d] = ogc_pkg::PLAN_TABLE[plan_q].fb;
		end else begin : g_bank
			assign ratio[d] = ogc_pkg::PLAN_TABLE[plan_q].bank[d];
		end
		// (RULE12) exact average by alternating ratios
		ogc_frac_div u_div (
			.clk     (CORE_CLK),
			.rst_n   (RESETN),
			.restart (restart),
			.ratio   (ratio[d]),
			.clk_out (div_clk[d])
		);
	end

	// bank gating
	always_comb begin
		for (int b = 0; b < NB; b++) begin
			// (RULE18) decision changes only while bank clock is low
			// (RULE17) both disables low to run
			// (RULE3) master disable stops every bank
			if (!div_clk[b]) begin
				run_d[b] = !roles_q.master_out_disable_n && !roles_q.bank_disable_n[b]
					&& (st_q == ST_RUN);
			end else begin
				run_d[b] = run_q[b];
			end
			// (RULE5) stopped bank held low
			// (RULE6) whole phases only
			out_d[b] = div_clk[b] & run_q[b];
		end
		fb_d = div_clk[ogc_pkg::FB_DIV];
		sq_d = (st_q != ST_RUN);
	end

	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			run_q <= '0;
			out_q <= '0;
			fb_q  <= 1'b0;
			sq_q  <= 1'b1;
		end else begin
			run_q <= run_d;
			out_q <= out_d;
			fb_q  <= fb_d;
			sq_q  <= sq_d;
		end
	end

	// (RULE4) each bank drives its pair from one gated flop
	assign BANK_A_CLOCK_PAIR = {2{out_q[0]}};
	assign BANK_B_CLOCK_PAIR = {2{out_q[1]}};
	assign BANK_C_CLOCK_PAIR = {2{out_q[2]}};
	assign BANK_D_CLOCK_PAIR = {2{out_q[3]}};
	assign FB_CLK            = fb_q;
	assign ACTIVE_PLAN       = plan_q;
	assign SQUELCH           = sq_q;
	// (RULE10) reference choice is a fixed constant
	assign REF_IS_CRYSTAL    = ogc_pkg::REF_IS_XTAL;

endmodule

// File: ogc_pkg.sv
package ogc_pkg;

	// pin and bank counts
	localparam int NUM_PINS  = 5;
	localparam int NUM_BANKS = 4;
	localparam int NUM_PLANS = 3;
	localparam int NUM_DIVS  = NUM_BANKS + 1;
	localparam int FB_DIV    = NUM_BANKS;

	// pin positions with restricted roles
	localparam int PIN_FIRST  = 0;
	localparam int PIN_SECOND = 1;
	localparam int PIN_THIRD  = 2;

	// role a multi-function pin is bound to at configuration time
	typedef enum logic [3:0] {
		FN_NONE,
		FN_MASTER,
		FN_BANK_A,
		FN_BANK_B,
		FN_BANK_C,
		FN_BANK_D,
		FN_SEL_LOW,
		FN_SEL_HIGH,
		FN_RESET
	} ogc_fn_t;

	// decoded pin roles
	typedef struct packed {
		logic       master_out_disable_n;
		logic [3:0] bank_disable_n;
		logic [1:0] plan_select_bus;
		logic       reset;
	} ogc_roles_t;

	// fractional ratio in half periods of the source: whole + num/den
	typedef struct packed {
		logic [15:0] whole;
		logic [15:0] num;
		logic [15:0] den;
	} ogc_ratio_t;

	typedef struct packed {
		ogc_ratio_t       fb;
		ogc_ratio_t [3:0] bank;
	} ogc_plan_t;

	// factory configuration
	localparam ogc_fn_t PIN_MAP [NUM_PINS] = '{FN_RESET, FN_SEL_LOW, FN_SEL_HIGH,
		FN_MASTER, FN_BANK_A};
	localparam int   PLAN_COUNT  = 3;
	localparam logic REF_IS_XTAL = 1'b1;
	localparam ogc_plan_t PLAN_TABLE [NUM_PLANS] = '{
		'{fb: '{16'h0004, 16'h0000, 16'h0001}, bank: '{
			'{16'h0002, 16'h0001, 16'h0003}, '{16'h0003, 16'h0000, 16'h0001},
			'{16'h0005, 16'h0002, 16'h0007}, '{16'h0001, 16'h0001, 16'h0002}}},
		'{fb: '{16'h0004, 16'h0000, 16'h0001}, bank: '{
			'{16'h0004, 16'h0003, 16'h0005}, '{16'h0002, 16'h0000, 16'h0001},
			'{16'h0006, 16'h0001, 16'h0004}, '{16'h0003, 16'h0001, 16'h0002}}},
		'{fb: '{16'h0004, 16'h0000, 16'h0001}, bank: '{
			'{16'h0001, 16'h0000, 16'h0001}, '{16'h0007, 16'h0005, 16'h0009},
			'{16'h0002, 16'h0002, 16'h0003}, '{16'h0008, 16'h0000, 16'h0001}}}
	};

	// reset values
	localparam logic [1:0] PLAN_RST = 2'h0;

	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int RST_MIN_NS    = 200;
	localparam int RST_MIN_CYC   = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RST_CNT_W     = $clog2(RST_MIN_CYC + 1);

	// output frequency range
	localparam int SRC_KHZ     = 100000;
	localparam int F_MIN_KHZ   = 1000;
	localparam int F_MAX_KHZ   = 200000;

endpackage

// File: ogc_frac_div.sv
`timescale 1ns/100ps

module ogc_frac_div (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               rst_n,
	// control
	input  wire logic               restart,
	input  wire ogc_pkg::ogc_ratio_t ratio,
	// divided clock
	output logic                    clk_out
);

	logic [15:0] cnt_q, cnt_d;
	logic [16:0] acc_q, acc_d;
	logic        clk_q, clk_d;
	logic [16:0] sum;
	logic        carry;

	always_comb begin
		sum   = acc_q + {1'b0, ratio.num};
		carry = (sum >= {1'b0, ratio.den});
		cnt_d = cnt_q;
		acc_d = acc_q;
		clk_d = clk_q;
		if (restart) begin
			cnt_d = ratio.whole;
			acc_d = 17'h00000;
			clk_d = 1'b0;
		end else if (cnt_q <= 16'h0001) begin
			clk_d = ~clk_q;
			// half period of whole or whole+1 by accumulator carry
			if (carry) begin
				cnt_d = ratio.whole + 16'h0001;
				acc_d = sum - {1'b0, ratio.den};
			end else begin
				cnt_d = ratio.whole;
				acc_d = sum;
			end
		end else begin
			cnt_d = cnt_q - 16'h0001;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 16'h0001;
			acc_q <= 17'h00000;
			clk_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			acc_q <= acc_d;
			clk_q <= clk_d;
		end
	end

	assign clk_out = clk_q;

endmodule

// File: ogc_top_props.sv
`timescale 1ns/100ps

module ogc_top_props (
	// clock and reset
	input wire logic       CORE_CLK,
	input wire logic       RESETN,
	// control pins
	input wire logic       MULTI_PIN_FIRST,
	input wire logic       MULTI_PIN_SECOND,
	input wire logic       MULTI_PIN_THIRD,
	input wire logic       MULTI_PIN_FOURTH,
	input wire logic       MULTI_PIN_FIFTH,
	// outputs
	input wire logic [1:0] BANK_A_CLOCK_PAIR,
	input wire logic [1:0] BANK_B_CLOCK_PAIR,
	input wire logic [1:0] BANK_C_CLOCK_PAIR,
	input wire logic [1:0] BANK_D_CLOCK_PAIR,
	input wire logic       FB_CLK,
	input wire logic [1:0] ACTIVE_PLAN,
	input wire logic       REF_IS_CRYSTAL,
	input wire logic       SQUELCH
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RESETN);
	logic [4:0] mst_q, mst_d, bka_q, bka_d;
	// cycles each disable pin has been held high
	always_comb begin
		mst_d = !MULTI_PIN_FOURTH ? 5'h0 : (mst_q == 5'h1f) ? mst_q : mst_q + 5'h1;
		bka_d = !MULTI_PIN_FIFTH ? 5'h0 : (bka_q == 5'h1f) ? bka_q : bka_q + 5'h1;
	end
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			mst_q <= 5'h0;
			bka_q <= 5'h0;
		end else begin
			mst_q <= mst_d;
			bka_q <= bka_d;
		end
	end
	pair_match_a: assert property (
		BANK_A_CLOCK_PAIR[0] == BANK_A_CLOCK_PAIR[1] && BANK_D_CLOCK_PAIR[0] == BANK_D_CLOCK_PAIR[1]
		&& BANK_B_CLOCK_PAIR[0] == BANK_B_CLOCK_PAIR[1]
		&& BANK_C_CLOCK_PAIR[0] == BANK_C_CLOCK_PAIR[1])
		else $error("bank pair bits differ");
	master_stop_a: assert property (
		mst_q >= 5'h14 |-> {BANK_A_CLOCK_PAIR, BANK_B_CLOCK_PAIR, BANK_C_CLOCK_PAIR,
		BANK_D_CLOCK_PAIR} == 8'h00) else $error("master disable left a bank running");
	bank_stop_a: assert property (
		bka_q >= 5'h14 |-> BANK_A_CLOCK_PAIR == 2'h0) else $error("bank a not held low");
	full_high_a: assert property (
		$rose(BANK_C_CLOCK_PAIR[0]) && ACTIVE_PLAN == 2'h0 && !SQUELCH
		|-> BANK_C_CLOCK_PAIR[0] [*3] ##1 !BANK_C_CLOCK_PAIR[0]) else $error("bank c high cut");
	full_low_a: assert property (
		$fell(BANK_C_CLOCK_PAIR[0]) && ACTIVE_PLAN == 2'h0 && !SQUELCH
		|-> !BANK_C_CLOCK_PAIR[0] [*3]) else $error("bank c low phase short");
	fb_half_a: assert property (
		$rose(FB_CLK) && !SQUELCH |-> FB_CLK [*4] ##1 !FB_CLK) else $error("feedback phase wrong");
	ref_fixed_a: assert property (
		REF_IS_CRYSTAL == ogc_pkg::REF_IS_XTAL) else $error("reference source moved");
	plan_range_a: assert property (
		ACTIVE_PLAN != 2'h3) else $error("plan index out of range");
	plan_hold_a: assert property (
		!SQUELCH && !$past(SQUELCH) |-> $stable(ACTIVE_PLAN)) else $error("plan changed in run");
	squelch_on_a: assert property (
		$rose(MULTI_PIN_FIRST) |-> ##[1:3] SQUELCH) else $error("reset pin did not squelch");
	cover property ($fell(SQUELCH) && ACTIVE_PLAN == 2'h2);
	cover property (mst_q == 5'h14);
	cover property (bka_q == 5'h14 && BANK_B_CLOCK_PAIR[0]);
endmodule

// File: ogc_board.sv
`timescale 1ns/100ps

module ogc_board (
	// clock
	input  wire logic clk,
	// control pins
	output logic       pin_reset,
	output logic [1:0] plan_select_bus,
	output logic       master_out_disable_n,
	output logic       bank_a_disable_n
);
	initial begin
		pin_reset = 1'b0;
		plan_select_bus = 2'h2;
		master_out_disable_n = 1'b0;
		bank_a_disable_n = 1'b0;
	end
	task automatic set_code(input logic [1:0] code);
		@(negedge clk);
		plan_select_bus = code;
	endtask
	// reset held for the given width
	task automatic pulse_reset(input int cyc);
		@(negedge clk);
		pin_reset = 1'b1;
		repeat (cyc) @(negedge clk);
		pin_reset = 1'b0;
	endtask
	task automatic set_enables(input logic mst, input logic bka);
		@(negedge clk);
		master_out_disable_n = mst;
		bank_a_disable_n = bka;
	endtask
endmodule

// File: ogc_top_tb.sv
`timescale 1ns/100ps

module ogc_top_tb;
	logic       core_clk, resetn, pin_rst, mdis_n, adis_n, fb_clk, ref_x, squelch;
	logic [1:0] sel, bk_a, bk_b, bk_c, bk_d, plan;
	int         err_count, check_count, rises [5];
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	ogc_board ogc_board_inst (.clk(core_clk), .pin_reset(pin_rst), .plan_select_bus(sel),
		.master_out_disable_n(mdis_n), .bank_a_disable_n(adis_n));
	ogc_top ogc_top_inst (.CORE_CLK(core_clk), .RESETN(resetn), .MULTI_PIN_FIRST(pin_rst),
		.MULTI_PIN_SECOND(sel[0]), .MULTI_PIN_THIRD(sel[1]), .MULTI_PIN_FOURTH(mdis_n),
		.MULTI_PIN_FIFTH(adis_n), .BANK_A_CLOCK_PAIR(bk_a), .BANK_B_CLOCK_PAIR(bk_b),
		.BANK_C_CLOCK_PAIR(bk_c), .BANK_D_CLOCK_PAIR(bk_d), .FB_CLK(fb_clk),
		.ACTIVE_PLAN(plan), .REF_IS_CRYSTAL(ref_x), .SQUELCH(squelch));
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	function automatic logic [1:0] exp_plan(input logic [1:0] code);
		return (code == 2'h0) ? 2'h0 : code - 2'h1;
	endfunction
	task automatic count_rises(input int cyc);
		logic [4:0] prev, cur;
		rises = '{default: 0};
		prev = 5'h1f;
		repeat (cyc) begin
			@(negedge core_clk);
			cur = {fb_clk, bk_d[0], bk_c[0], bk_b[0], bk_a[0]};
			for (int i = 0; i < 5; i++) rises[i] += int'(cur[i] && !prev[i]);
			prev = cur;
		end
	endtask
	task automatic tally_and_finish();
		if (err_count == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge core_clk);
		err_count++;
		tally_and_finish();
	end
	initial begin
		int                  seed, e;
		logic [1:0]          code;
		ogc_pkg::ogc_ratio_t r;
		err_count = 0;
		check_count = 0;
		resetn = 1'b0;
		seed = $urandom(62090);
		repeat (8) @(negedge core_clk);
		resetn = 1'b1;
		repeat (10) @(negedge core_clk);
		check("power-on plan", 8'(exp_plan(2'h2)), 8'(plan));
		check("crystal ref", 8'(ogc_pkg::REF_IS_XTAL), 8'(ref_x));
		for (int k = 0; k < 4; k++) begin
			code = 2'(k + 2);
			ogc_board_inst.set_code(code);
			ogc_board_inst.pulse_reset(ogc_pkg::RST_MIN_CYC + 4);
			repeat (12) @(negedge core_clk);
			check("reloaded plan", 8'(exp_plan(code)), 8'(plan));
			check("squelch", 8'h0, 8'(squelch));
			count_rises(400);
			for (int i = 0; i < 5; i++) begin
				r = (i < 4) ? ogc_pkg::PLAN_TABLE[exp_plan(code)].bank[i]
					: ogc_pkg::PLAN_TABLE[exp_plan(code)].fb;
				e = 400 * int'(r.den) / (2 * (int'(r.whole) * int'(r.den) + int'(r.num)));
				check("rate", 8'h1, 8'(rises[i] - e inside {-1, 0, 1}));
			end
		end
		ogc_board_inst.set_code(2'h3);
		ogc_board_inst.pulse_reset(5);
		repeat (12) @(negedge core_clk);
		check("short reset plan", 8'h0, 8'(plan));
		ogc_board_inst.set_enables(1'b1, 1'b0);
		repeat (30) @(negedge core_clk);
		check("master off", 8'h0, {bk_a, bk_b, bk_c, bk_d});
		ogc_board_inst.set_enables(1'b0, 1'b1);
		repeat (30) @(negedge core_clk);
		count_rises(60);
		check("bank a off", 8'h0, 8'(rises[0]));
		check("bank b on", 8'h1, 8'(rises[1] > 0));
		for (int k = 0; k < 60; k++) begin
			ogc_board_inst.set_enables(1'($urandom), 1'($urandom));
			repeat ($urandom_range(1, 12)) @(negedge core_clk);
		end
		ogc_board_inst.set_code(2'h3);
		@(negedge core_clk);
		resetn = 1'b0;
		repeat (3) @(negedge core_clk);
		check("reset squelch", 8'h1, 8'(squelch));
		check("reset outputs", 8'h0, {bk_a, bk_b, bk_c, bk_d});
		resetn = 1'b1;
		repeat (10) @(negedge core_clk);
		check("power-on reload", 8'(exp_plan(2'h3)), 8'(plan));
		tally_and_finish();
	end
endmodule

bind ogc_top ogc_top_props ogc_top_props_inst (.CORE_CLK(CORE_CLK), .RESETN(RESETN),
	.MULTI_PIN_FIRST(MULTI_PIN_FIRST), .MULTI_PIN_SECOND(MULTI_PIN_SECOND),
	.MULTI_PIN_THIRD(MULTI_PIN_THIRD), .MULTI_PIN_FOURTH(MULTI_PIN_FOURTH),
	.MULTI_PIN_FIFTH(MULTI_PIN_FIFTH), .BANK_A_CLOCK_PAIR(BANK_A_CLOCK_PAIR),
	.BANK_B_CLOCK_PAIR(BANK_B_CLOCK_PAIR), .BANK_C_CLOCK_PAIR(BANK_C_CLOCK_PAIR),
	.BANK_D_CLOCK_PAIR(BANK_D_CLOCK_PAIR), .FB_CLK(FB_CLK), .ACTIVE_PLAN(ACTIVE_PLAN),
	.REF_IS_CRYSTAL(REF_IS_CRYSTAL), .SQUELCH(SQUELCH));
